// ===== rtl/ftl_runtime_regs.sv
// ftl_runtime_regs: runtime register bank for two fan tachometer
// channels, two indicator lamps and a keyboard code holding byte.
// assumes a plain single-cycle register port on i_clock; read data
// appear in the cycle after the read strobe and only there.
//
// Added by the designer: the strobed register port.
`timescale 1ns/100ps
module ftl_runtime_regs
   import ftl_pkg::*;
#(
   parameter int BLINK_CYCLES = BLINK_PHASE_CYCLES,
   parameter int TACH_CYCLES  = TACH_BASE_CYCLES
) (
   input  wire logic       i_clock,
   input  wire logic       i_reset,
   input  wire logic [7:0] i_address,
   input  wire logic [7:0] i_write_data,
   input  wire logic       i_write,
   input  wire logic       i_read,
   output logic      [7:0] o_read_data,
   input  wire logic       i_fan_channel_a_tach,
   input  wire logic       i_fan_channel_b_tach,
   input  wire logic [1:0] i_fan_channel_a_divisor,
   input  wire logic [1:0] i_fan_channel_b_divisor,
   output logic            o_indicator_a,
   output logic            o_indicator_b
);

   // stored register contents
   ftl_byte_t  fan_one_count_start;
   ftl_byte_t  fan_two_count_start;
   logic [1:0] indicator_a_control;
   logic [1:0] indicator_b_control;
   ftl_byte_t  keyboard_code_hold;

   // restart pulses toward the channels
   logic       restart_a;
   logic       restart_b;

   // links to the two tachometer channels
   ftl_tach_if tach_a ();
   ftl_tach_if tach_b ();

   // true when an address falls in the unused span at the top of the map
   function automatic logic in_reserved(input ftl_byte_t addr);
      in_reserved = (addr >= OFS_RSVD_FIRST) && (addr <= OFS_RSVD_LAST);
   endfunction

   // address decode
   wire hit_fan_a_count = (i_address == OFS_FAN_A_COUNT);
   wire hit_fan_b_count = (i_address == OFS_FAN_B_COUNT);
   wire hit_fan_a_start = (i_address == OFS_FAN_A_START);
   wire hit_fan_b_start = (i_address == OFS_FAN_B_START);
   wire hit_indicator_a = (i_address == OFS_INDICATOR_A);
   wire hit_indicator_b = (i_address == OFS_INDICATOR_B);
   wire hit_key_code    = (i_address == OFS_KEY_CODE);
   wire hit_reserved    = in_reserved(i_address);

   // write enables; count registers are read only and take no write
   wire wr_fan_a_start  = i_write & hit_fan_a_start;
   wire wr_fan_b_start  = i_write & hit_fan_b_start;
   wire wr_indicator_a  = i_write & hit_indicator_a;
   wire wr_indicator_b  = i_write & hit_indicator_b;
   wire wr_key_code     = i_write & hit_key_code;

   // indicator field as written, reserved bits dropped
   wire [1:0] write_indicator = i_write_data[INDICATOR_LSB +: INDICATOR_W];

   // read selection; anything unmapped or reserved answers zero
   ftl_byte_t read_select;
   always_comb begin
      read_select = 8'h00;
      if (hit_fan_a_count) begin
         read_select = tach_a.count;
      end else if (hit_fan_b_count) begin
         read_select = tach_b.count;
      end else if (hit_fan_a_start) begin
         read_select = fan_one_count_start;
      end else if (hit_fan_b_start) begin
         read_select = fan_two_count_start;
      end else if (hit_indicator_a) begin
         read_select = {6'h00, indicator_a_control};
      end else if (hit_indicator_b) begin
         read_select = {6'h00, indicator_b_control};
      end else if (hit_key_code) begin
         read_select = keyboard_code_hold;
      end else if (hit_reserved) begin
         read_select = 8'h00;
      end else begin
         read_select = 8'h00;
      end
   end

   // read data stand only in the cycle after the strobe, zero otherwise,
   // so a stale value never looks like a fresh answer
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         o_read_data <= 8'h00;
      end else if (i_read) begin
         o_read_data <= read_select;
      end else begin
         o_read_data <= 8'h00;
      end
   end

   // preload registers, one per channel
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         fan_one_count_start <= RST_COUNT_START;
         fan_two_count_start <= RST_COUNT_START;
      end else begin
         if (wr_fan_a_start) begin
            fan_one_count_start <= i_write_data;
         end
         if (wr_fan_b_start) begin
            fan_two_count_start <= i_write_data;
         end
      end
   end

   // preload write restarts
   // the pulse trails the write strobe by a cycle, landing with the store, so the channel loads the new
   // preload; rewriting the same value restarts as well
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         restart_a <= 1'b0;
         restart_b <= 1'b0;
      end else begin
         restart_a <= wr_fan_a_start;
         restart_b <= wr_fan_b_start;
      end
   end

   // indicator control fields; only the two low bits are kept
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         indicator_a_control <= RST_INDICATOR;
         indicator_b_control <= RST_INDICATOR;
      end else begin
         if (wr_indicator_a) begin
            indicator_a_control <= write_indicator;
         end
         if (wr_indicator_b) begin
            indicator_b_control <= write_indicator;
         end
      end
   end

   // keyboard code byte
   // stored as written, bit 0 lsb; no effect on any other logic
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         keyboard_code_hold <= RST_KEY_CODE;
      end else if (wr_key_code) begin
         keyboard_code_hold <= i_write_data;
      end
   end

   assign tach_a.start   = fan_one_count_start;
   assign tach_b.start   = fan_two_count_start;
   assign tach_a.restart = restart_a;
   assign tach_b.restart = restart_b;

   // divisor to channel
   // the divisor comes from the outside control register, whose reset
   // value selects divide by two
   assign tach_a.divisor = i_fan_channel_a_divisor;
   assign tach_b.divisor = i_fan_channel_b_divisor;

   ftl_tach #(
      .BASE_CYCLES (TACH_CYCLES)
   ) u_tach_a (
      .i_clock     (i_clock),
      .i_reset     (i_reset),
      .i_tach      (i_fan_channel_a_tach),
      .link        (tach_a.tach)
   );

   ftl_tach #(
      .BASE_CYCLES (TACH_CYCLES)
   ) u_tach_b (
      .i_clock     (i_clock),
      .i_reset     (i_reset),
      .i_tach      (i_fan_channel_b_tach),
      .link        (tach_b.tach)
   );

   // indicator lamp drive
   // both lamps run from one frame counter to save area
   ftl_blink #(
      .PHASE_CYCLES (BLINK_CYCLES)
   ) u_blink (
      .i_clock      (i_clock),
      .i_reset      (i_reset),
      .i_mode_a     (indicator_a_control),
      .i_mode_b     (indicator_b_control),
      .o_led_a      (o_indicator_a),
      .o_led_b      (o_indicator_b)
   );

endmodule

// ===== common/ftl_pkg.sv
// ftl_pkg: offsets, reset values, field layout, codes and timing of the
// fan tachometer, indicator and keyboard code registers.
// assumes a single 125 MHz clock and byte-wide registers at byte offsets.
package ftl_pkg;

   typedef logic [7:0] ftl_byte_t;

   // register offsets
   localparam ftl_byte_t OFS_FAN_A_COUNT     = 8'h59;
   localparam ftl_byte_t OFS_FAN_B_COUNT     = 8'h5a;
   localparam ftl_byte_t OFS_FAN_A_START     = 8'h5b;
   localparam ftl_byte_t OFS_FAN_B_START     = 8'h5c;
   localparam ftl_byte_t OFS_INDICATOR_A     = 8'h5d;
   localparam ftl_byte_t OFS_INDICATOR_B     = 8'h5e;
   localparam ftl_byte_t OFS_KEY_CODE        = 8'h5f;
   localparam ftl_byte_t OFS_RSVD_FIRST      = 8'h60;
   localparam ftl_byte_t OFS_RSVD_LAST       = 8'h7f;

   // reset values
   localparam ftl_byte_t  RST_PULSE_COUNT    = 8'h00;
   localparam ftl_byte_t  RST_COUNT_START    = 8'h00;
   localparam logic [1:0] RST_INDICATOR      = 2'h0;
   localparam ftl_byte_t  RST_KEY_CODE       = 8'h00;

   // indicator control field
   localparam int         INDICATOR_LSB      = 0;
   localparam int         INDICATOR_W        = 2;
   localparam logic [1:0] IND_OFF            = 2'h0;
   localparam logic [1:0] IND_BLINK_EVEN     = 2'h1;
   localparam logic [1:0] IND_BLINK_SHORT    = 2'h2;
   localparam logic [1:0] IND_ON             = 2'h3;

   // tachometer divisor codes
   localparam logic [1:0] DIV_BY_1           = 2'h0;
   localparam logic [1:0] DIV_BY_2           = 2'h1;
   localparam logic [1:0] DIV_BY_4           = 2'h2;
   localparam logic [1:0] DIV_BY_8           = 2'h3;
   localparam logic [1:0] DIV_DEFAULT        = DIV_BY_2;
   localparam ftl_byte_t  COUNT_MAX          = 8'hff;

   // timing
   localparam int CLOCK_HZ                   = 125_000_000;
   localparam int BLINK_PHASE_MS             = 500;
   localparam int BLINK_PHASE_CYCLES         = CLOCK_HZ / 1000 * BLINK_PHASE_MS;
   localparam int TACH_TICK_HZ               = 22_500;
   localparam int TACH_BASE_CYCLES           = CLOCK_HZ / TACH_TICK_HZ;

   // tachometer channel states
   typedef enum logic [1:0] {
      TACH_WAIT_EDGE = 2'b01,
      TACH_COUNTING  = 2'b10
   } ftl_tach_state_e;

endpackage

// ===== common/ftl_tach_if.sv
// ftl_tach_if: link between the register bank and one tachometer channel.
// assumes the bank drives start, restart and divisor; the channel the count.
`timescale 1ns/100ps
interface ftl_tach_if;
   logic [7:0] start;    // preload value
   logic       restart;  // one-cycle pulse after a preload write
   logic [1:0] divisor;  // tick scaling code
   logic [7:0] count;    // latched pulse count

   modport bank (output start, output restart, output divisor, input count);
   modport tach (input start, input restart, input divisor, output count);
endinterface

// ===== rtl/ftl_tach.sv
// ftl_tach: one fan tachometer channel, counts scaled ticks per fan pulse.
// assumes the fan pulse is asynchronous and the link restart is a pulse.
`timescale 1ns/100ps
module ftl_tach
   import ftl_pkg::*;
#(
   parameter int BASE_CYCLES = TACH_BASE_CYCLES
) (
   input  wire logic i_clock,
   input  wire logic i_reset,
   input  wire logic i_tach,
   ftl_tach_if.tach  link
);
   localparam int PW = $clog2(BASE_CYCLES + 1);
   localparam logic [PW-1:0] BASE_LAST = PW'(BASE_CYCLES - 1);

   logic [2:0]      sync;
   logic            level;
   logic            level_d;
   logic [PW-1:0]   prescale;
   logic [2:0]      div_count;
   logic [7:0]      running;
   ftl_tach_state_e state;

   wire             rise      = level & ~level_d;
   wire             base_tick = (prescale == BASE_LAST);
   wire [2:0]       div_last  = 3'((4'h1 << link.divisor) - 4'h1);
   wire             tick      = base_tick & (div_count == div_last);
   wire [7:0]       next_running = (running == COUNT_MAX) ? running : running + 8'h01;

   // three-stage sampling; the level moves only when the last two agree
   always_ff @(posedge i_clock) begin
      sync    <= {sync[1:0], i_tach};
      level_d <= level;
      if (i_reset) begin
         level <= 1'b0;
      end else if (sync[2] == sync[1]) begin
         level <= sync[2];
      end
   end

   // tick timebase; restarted with the count so a new period starts clean
   always_ff @(posedge i_clock) begin
      if (i_reset || link.restart || base_tick) begin
         prescale <= '0;
      end else begin
         prescale <= prescale + PW'(1);
      end
      if (i_reset || link.restart || tick) begin
         div_count <= 3'h0;
      end else if (base_tick) begin
         div_count <= div_count + 3'h1;
      end
   end

   // pulse period counter; first edge after a restart only opens a period
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         state      <= TACH_WAIT_EDGE;
         running    <= RST_COUNT_START;
         link.count <= RST_PULSE_COUNT;
      end else if (link.restart) begin
         state   <= TACH_WAIT_EDGE;
         running <= link.start;
      end else begin
         case (state)
            TACH_WAIT_EDGE: begin
               if (rise) begin
                  state   <= TACH_COUNTING;
                  running <= link.start;
               end
            end
            TACH_COUNTING: begin
               if (rise) begin
                  link.count <= running;
                  running    <= link.start;
               end else if (tick) begin
                  running <= next_running;
               end
            end
            default: state <= TACH_WAIT_EDGE;
         endcase
      end
   end
endmodule

// ===== rtl/ftl_blink.sv
// ftl_blink: shared half-second timebase driving both indicator outputs.
// assumes control codes come from flops on the same clock.
`timescale 1ns/100ps
module ftl_blink
   import ftl_pkg::*;
#(
   parameter int PHASE_CYCLES = BLINK_PHASE_CYCLES
) (
   input  wire logic       i_clock,
   input  wire logic       i_reset,
   input  wire logic [1:0] i_mode_a,
   input  wire logic [1:0] i_mode_b,
   output logic            o_led_a,
   output logic            o_led_b
);
   localparam int CW = $clog2(PHASE_CYCLES + 1);
   localparam logic [CW-1:0] PHASE_LAST = CW'(PHASE_CYCLES - 1);

   logic [CW-1:0] phase_count;
   logic [1:0]    phase;       // four half-second slots, a two second frame

   // lamp level for a control code in the current slot
   function automatic logic led_level(input logic [1:0] mode, input logic [1:0] slot);
      case (mode)
         IND_OFF:         led_level = 1'b0;
         IND_ON:          led_level = 1'b1;
         IND_BLINK_EVEN:  led_level = ~slot[0];
         IND_BLINK_SHORT: led_level = (slot == 2'h0);
         default:         led_level = 1'b0;
      endcase
   endfunction

   // free running frame; both lamps share it so their blinks stay in step
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         phase_count <= '0;
         phase       <= 2'h0;
      end else if (phase_count == PHASE_LAST) begin
         phase_count <= '0;
         phase       <= phase + 2'h1;
      end else begin
         phase_count <= phase_count + CW'(1);
      end
   end

   // registered lamp outputs
   always_ff @(posedge i_clock) begin
      if (i_reset) begin
         o_led_a <= 1'b0;
         o_led_b <= 1'b0;
      end else begin
         o_led_a <= led_level(i_mode_a, phase);
         o_led_b <= led_level(i_mode_b, phase);
      end
   end
endmodule

// ===== dv/ftl_runtime_regs_properties.sv
// ftl_regs_props: port-level checks for the runtime register bank.
// assumes plain one-cycle strobes; back to back accesses are legal, so the
// read-back checks demand a quiet cycle between the write and the read.
`timescale 1ns/100ps
module ftl_regs_props
   import ftl_pkg::*;
(
   input wire logic       i_clock,
   input wire logic       i_reset,
   input wire logic [7:0] i_address,
   input wire logic [7:0] i_write_data,
   input wire logic       i_write,
   input wire logic       i_read,
   input wire logic [7:0] o_read_data,
   input wire logic       o_indicator_a,
   input wire logic       o_indicator_b
);
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (i_reset);

   // write decodes for the two lamp registers
   wire wa = i_write && i_address == OFS_INDICATOR_A;
   wire wb = i_write && i_address == OFS_INDICATOR_B;
   wire in_rsvd = i_address >= OFS_RSVD_FIRST && i_address <= OFS_RSVD_LAST;

   idle_zero_a: assert property (!i_read |=> o_read_data == 8'h00)
      else $error("read data not zero outside a read");
   rsvd_zero_a: assert property (i_read && in_rsvd |=> o_read_data == 8'h00)
      else $error("reserved offset read not zero");
   key_code_a: assert property (i_write && i_address == OFS_KEY_CODE ##1 !i_write
      ##1 i_read && i_address == OFS_KEY_CODE |=> o_read_data == $past(i_write_data, 3))
      else $error("key code read back differs");
   preload_rw_a: assert property (i_write && i_address == OFS_FAN_A_START ##1 !i_write
      ##1 i_read && i_address == OFS_FAN_A_START |=> o_read_data == $past(i_write_data, 3))
      else $error("preload read back differs");
   ind_bits_a: assert property (i_read && (i_address == OFS_INDICATOR_A ||
      i_address == OFS_INDICATOR_B) |=> o_read_data[7:2] == 6'h00)
      else $error("lamp register upper bits not zero");
   lamp_on_a: assert property (wa && i_write_data[1:0] == IND_ON ##1 !wa [*2]
      |=> o_indicator_a)
      else $error("lamp a not on for code on");
   lamp_off_a: assert property (wb && i_write_data[1:0] == IND_OFF ##1 !wb [*2]
      |=> !o_indicator_b)
      else $error("lamp b not off for code off");
   // reset must be checked while it is asserted, so no disable here
   reset_quiet_a: assert property (disable iff (1'b0) i_reset |=>
      o_read_data == 8'h00 && !o_indicator_a && !o_indicator_b)
      else $error("outputs active after a reset edge");

   cover property (i_read && in_rsvd);
   cover property (wa && i_write_data[1:0] == IND_BLINK_SHORT);
   cover property (i_read && i_address == OFS_FAN_A_COUNT ##1 o_read_data == COUNT_MAX);
endmodule

bind ftl_runtime_regs ftl_regs_props u_ftl_regs_props (
   .i_clock, .i_reset, .i_address, .i_write_data, .i_write, .i_read,
   .o_read_data, .o_indicator_a, .o_indicator_b
);

// ===== dv/testbench.sv
// testbench: directed regression for the runtime register bank.
// assumes short blink and tick parameters; both fan pins share one pulse.
`timescale 1ns/100ps
module testbench
   import ftl_pkg::*;
;
   localparam int BC = 8;
   localparam int TC = 4;
   logic       i_clock, i_reset, i_write, i_read, tach;
   logic [7:0] i_address, i_write_data, o_read_data;
   logic [1:0] div_a, div_b;
   logic       o_indicator_a, o_indicator_b;
   int         num_errors, num_checks, cycles;

   ftl_runtime_regs #(.BLINK_CYCLES(BC), .TACH_CYCLES(TC)) u_ftl_runtime_regs (
      .i_clock, .i_reset, .i_address, .i_write_data, .i_write, .i_read, .o_read_data,
      .i_fan_channel_a_tach(tach), .i_fan_channel_b_tach(tach),
      .i_fan_channel_a_divisor(div_a), .i_fan_channel_b_divisor(div_b),
      .o_indicator_a, .o_indicator_b
   );

   // clock at 125 MHz
   initial begin
      i_clock = 1'b0;
      forever #4 i_clock = ~i_clock;
   end

   // hang guard, well above the expected run of about two thousand cycles
   always @(posedge i_clock) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         num_errors++;
         summarize();
      end
   end

   // tol 1 absorbs the pin sampler's phase against the tick prescaler
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input int tol = 0);
      num_checks++;
      if (got !== exp && (tol == 0 || (got !== exp + 8'h01 && got !== exp - 8'h01))) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clock);
      i_write <= 1'b1;
      i_address <= a;
      i_write_data <= d;
      @(posedge i_clock);
      i_write <= 1'b0;
   endtask

   // read data stand only in the cycle after the read edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_clock);
      i_read <= 1'b1;
      i_address <= a;
      @(posedge i_clock);
      i_read <= 1'b0;
      #1;
      d = o_read_data;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] exp, input int tol = 0);
      logic [7:0] v;
      rd(a, v);
      chk(v, exp, tol);
   endtask

   task automatic pulses(input int n, input int p);
      repeat (n) begin
         @(posedge i_clock);
         tach <= 1'b1;
         repeat (p / 2) @(posedge i_clock);
         tach <= 1'b0;
         repeat (p / 2 - 1) @(posedge i_clock);
      end
      repeat (8) @(posedge i_clock);
   endtask

   task automatic t_reset;
      for (int a = 8'h59; a <= 8'h60; a++) begin
         rchk(8'(a), 8'h00);
      end
      $display("done reset values");
   endtask

   task automatic t_rw;
      wr(OFS_FAN_A_START, 8'h5a);
      rchk(OFS_FAN_A_START, 8'h5a);
      wr(OFS_FAN_B_START, 8'ha5);
      rchk(OFS_FAN_B_START, 8'ha5);
      wr(OFS_KEY_CODE, 8'h01);
      rchk(OFS_KEY_CODE, 8'h01);
      wr(OFS_KEY_CODE, 8'h80);
      rchk(OFS_KEY_CODE, 8'h80);
      wr(OFS_INDICATOR_A, 8'hfe);
      rchk(OFS_INDICATOR_A, 8'h02);
      wr(OFS_INDICATOR_B, 8'hfd);
      rchk(OFS_INDICATOR_B, 8'h01);
      wr(OFS_FAN_A_COUNT, 8'h77);
      rchk(OFS_FAN_A_COUNT, 8'h00);
      wr(OFS_RSVD_FIRST, 8'hff);
      rchk(OFS_RSVD_FIRST, 8'h00);
      wr(OFS_RSVD_LAST, 8'hff);
      rchk(OFS_RSVD_LAST, 8'h00);
      $display("done read write");
   endtask

   // same tick count per period on a for every divisor; b stays at /1
   task automatic t_tach;
      for (int d = 0; d < 4; d++) begin
         @(posedge i_clock);
         div_a <= d[1:0];
         wr(OFS_FAN_A_START, 8'h20);
         wr(OFS_FAN_B_START, 8'h40);
         pulses(3, 6 * (TC << d));
         rchk(OFS_FAN_A_COUNT, 8'h26, 1);
         rchk(OFS_FAN_B_COUNT, 8'h40 + 8'(6 << d), 1);
      end
      $display("done tachometer");
   endtask

   task automatic t_sat;
      @(posedge i_clock);
      div_a <= DIV_BY_1;
      wr(OFS_FAN_A_START, 8'hf0);
      pulses(3, 25 * TC);
      rchk(OFS_FAN_A_COUNT, COUNT_MAX);
      $display("done saturation");
   endtask

   // first rise after a preload write only opens a period, so the old count
   // stays; without the restart it would latch a partial count instead
   task automatic t_restart;
      wr(OFS_FAN_A_START, 8'h10);
      pulses(3, 6 * TC);
      rchk(OFS_FAN_A_COUNT, 8'h16, 1);
      wr(OFS_FAN_A_START, 8'h80);
      pulses(1, 6 * TC);
      rchk(OFS_FAN_A_COUNT, 8'h16, 1);
      wr(OFS_KEY_CODE, 8'h3c);
      wr(OFS_INDICATOR_A, 8'h03);
      // mid-run reset clears every register and the latched count
      @(posedge i_clock);
      i_reset <= 1'b1;
      repeat (4) @(posedge i_clock);
      i_reset <= 1'b0;
      rchk(OFS_FAN_A_COUNT, 8'h00);
      rchk(OFS_FAN_A_START, 8'h00);
      rchk(OFS_INDICATOR_A, 8'h00);
      rchk(OFS_KEY_CODE, 8'h00);
      $display("done restart and reset");
   endtask

   // on cycles over one four-slot frame, independent of frame phase
   task automatic t_lamp;
      int on_a, on_b;
      int slots[4] = '{0, 2, 1, 4};
      for (int k = 0; k < 4; k++) begin
         wr(OFS_INDICATOR_A, 8'(k));
         wr(OFS_INDICATOR_B, 8'(3 - k));
         repeat (4) @(posedge i_clock);
         on_a = 0;
         on_b = 0;
         repeat (4 * BC) begin
            @(posedge i_clock);
            #1;
            on_a += int'(o_indicator_a === 1'b1);
            on_b += int'(o_indicator_b === 1'b1);
         end
         chk(8'(on_a), 8'(slots[k] * BC));
         chk(8'(on_b), 8'(slots[3 - k] * BC));
      end
      $display("done indicators");
   endtask

   task automatic summarize;
      $display("checks=%0d errors=%0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial begin
      i_reset = 1'b1;
      i_write = 1'b0;
      i_read = 1'b0;
      i_address = 8'h00;
      i_write_data = 8'h00;
      tach = 1'b0;
      div_a = DIV_DEFAULT;
      div_b = DIV_BY_1;
      num_errors = 0;
      num_checks = 0;
      cycles = 0;
      repeat (10) @(posedge i_clock);
      i_reset <= 1'b0;
      t_reset();
      t_rw();
      t_tach();
      t_sat();
      t_restart();
      t_lamp();
      summarize();
   end
endmodule
